// file: smode_pkg.sv
// Constants for simplified mode-command descriptor storage
package smode_pkg;

   // ==========================================================
   // Register offsets (register port, word addressed)
   // ==========================================================
   localparam logic [7:0] OFS_RT1_ST_FIRST  = 8'h1E;
   localparam logic [7:0] OFS_RT1_ST_SECOND = 8'h1F;
   localparam logic [7:0] OFS_RT2_ST_FIRST  = 8'h27;
   localparam logic [7:0] OFS_RT2_ST_SECOND = 8'h28;
   localparam logic [7:0] OFS_RT1_CFG       = 8'h40;
   localparam logic [7:0] OFS_RT1_DESC_BASE = 8'h41;
   localparam logic [7:0] OFS_RT2_CFG       = 8'h42;
   localparam logic [7:0] OFS_RT2_DESC_BASE = 8'h43;
   localparam logic [7:0] OFS_STATUS        = 8'h44;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CFG_SIMPLIFIED_BIT = 0;
   localparam int CFG_ALT_ST_BIT     = 1;
   localparam int CTRL_BROADCAST_RECEIVED_FLAG_BIT     = 9;
   localparam int CTRL_ACCESSED_BIT  = 11;
   localparam int CMD_TR_BIT         = 10;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [15:0] RST_CFG       = 16'h0000;
   localparam logic [15:0] RST_DESC_BASE = 16'h0000;
   localparam logic [15:0] RST_ST_WORD   = 16'h0000;
   localparam logic [15:0] RST_LAST_CMD  = 16'h0000;

   // ==========================================================
   // Command decoding and descriptor layout
   // ==========================================================
   localparam logic [4:0] SA_MODE_A        = 5'h00;
   localparam logic [4:0] SA_MODE_B        = 5'h1F;
   localparam logic [4:0] MC_FIRST_DATA    = 5'h10;
   localparam logic [4:0] MC_LAST_COMMAND  = 5'h12;
   localparam logic [4:0] MC_SELFTEST_WORD = 5'h13;
   localparam logic [1:0] DW_CONTROL       = 2'h0;
   localparam logic [1:0] DW_MSG_INFO      = 2'h1;
   localparam logic [1:0] DW_TIME_TAG      = 2'h2;
   localparam logic [1:0] DW_MODE_DATA     = 2'h3;

endpackage : smode_pkg

// file: smode_desc_addr.sv
// Descriptor word address for one mode command
`timescale 1ns/1ps
module smode_desc_addr
(
   input  wire logic [15:0] base,
   input  wire logic        tr,
   input  wire logic [4:0]  code,
   input  wire logic [1:0]  word,
   output logic      [15:0] addr
);

   // Four words per descriptor, receive block then transmit block
   assign addr = base + {8'h00, tr, code, word};

endmodule : smode_desc_addr

// file: smode_rt_ctx.sv
// Per-terminal configuration, self-test words and last command
`timescale 1ns/1ps
module smode_rt_ctx
#(
   parameter logic [7:0] OFS_CFG  = 8'h00,
   parameter logic [7:0] OFS_BASE = 8'h01,
   parameter logic [7:0] OFS_ST0  = 8'h02,
   parameter logic [7:0] OFS_ST1  = 8'h03
)
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        last_we,
   input  wire logic [15:0] last_in,
   output logic             simplified,
   output logic [15:0]      desc_base,
   output logic [15:0]      selftest_word,
   output logic [15:0]      last_cmd,
   output logic             rd_hit,
   output logic [15:0]      rd_data
);

   logic [15:0] cfg_q;
   logic [15:0] base_q;
   logic [15:0] st0_q;
   logic [15:0] st1_q;
   logic [15:0] last_q;

   // ==========================================================
   // Software registers
   // ==========================================================
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg_q  <= smode_pkg::RST_CFG;
         base_q <= smode_pkg::RST_DESC_BASE;
         st0_q  <= smode_pkg::RST_ST_WORD;
         st1_q  <= smode_pkg::RST_ST_WORD;
      end
      else if (reg_wr)
      begin
         if (reg_addr == OFS_CFG)
            cfg_q <= reg_wdata & 16'h0003;
         if (reg_addr == OFS_BASE)
            base_q <= reg_wdata;
         if (reg_addr == OFS_ST0)
            st0_q <= reg_wdata;
         if (reg_addr == OFS_ST1)
            st1_q <= reg_wdata;
      end
   end

   // Most recently transacted command of this terminal
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         last_q <= smode_pkg::RST_LAST_CMD;
      else if (last_we)
         last_q <= last_in;
   end

   assign simplified = cfg_q[smode_pkg::CFG_SIMPLIFIED_BIT];
   assign desc_base  = base_q;
   assign selftest_word = cfg_q[smode_pkg::CFG_ALT_ST_BIT] ? st1_q : st0_q;
   assign last_cmd   = last_q;

   always_comb
   begin
      rd_hit  = 1'b1;
      rd_data = 16'h0000;
      if (reg_addr == OFS_CFG)
         rd_data = cfg_q;
      else if (reg_addr == OFS_BASE)
         rd_data = base_q;
      else if (reg_addr == OFS_ST0)
         rd_data = st0_q;
      else if (reg_addr == OFS_ST1)
         rd_data = st1_q;
      else
         rd_hit = 1'b0;
   end

endmodule : smode_rt_ctx

// file: smode_cmd_store.sv
// Simplified mode-command descriptor storage for two remote terminals
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module smode_cmd_store
(
   input  wire logic        clock,
   input  wire logic        nrst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Protocol engine side
   input  wire logic        cmd_valid,
   input  wire logic        cmd_rt,
   input  wire logic [15:0] cmd_word,
   input  wire logic        msg_done,
   input  wire logic        msg_abort,
   input  wire logic        msg_broadcast_received_flag,
   input  wire logic [15:0] msg_info,
   input  wire logic [15:0] msg_time,
   input  wire logic [15:0] msg_rx_data,
   output logic             tx_valid,
   output logic      [15:0] tx_data,
   output logic             commit_done,
   output logic             busy,
   // Shared RAM port
   output logic      [15:0] ram_addr,
   output logic      [15:0] ram_wdata,
   output logic             ram_we,
   output logic             ram_re,
   input  wire logic [15:0] ram_rdata
);

   typedef enum {
      ST_IDLE,
      ST_TX_RD,
      ST_TX_DATA,
      ST_WAIT_MSG,
      ST_W1_RD,
      ST_W1_DATA,
      ST_W1_WR,
      ST_W2_WR,
      ST_W3_WR,
      ST_W4_WR
   } state_t;

   state_t      state_q;
   logic        rt_q;
   logic        tr_q;
   logic [4:0]  code_q;
   logic        own_q;
   logic [15:0] cmd_q;
   logic [15:0] info_q;
   logic [15:0] time_q;
   logic [15:0] data_q;
   logic        data_wr_q;
   logic        broadcast_received_flag_q;
   logic [15:0] ctrl_merge;
   logic [1:0]  word_sel;
   logic [15:0] word_addr;
   logic [15:0] base_sel;
   logic [15:0] ram_addr_q;
   logic [15:0] ram_wdata_q;
   logic        ram_we_q;
   logic        ram_re_q;
   logic        tx_valid_q;
   logic [15:0] tx_data_q;
   logic        commit_q;
   logic [15:0] rdata_q;

   logic        simp1;
   logic        simp2;
   logic [15:0] base1;
   logic [15:0] base2;
   logic [15:0] st1;
   logic [15:0] st2;
   logic [15:0] last1;
   logic [15:0] last2;
   logic        hit1;
   logic        hit2;
   logic [15:0] rd1;
   logic [15:0] rd2;
   logic        last_we1;
   logic        last_we2;

   logic        is_mode;
   logic        cmd_tr;
   logic [4:0]  cmd_code;
   logic        cmd_simp;
   logic        has_data;

   // ==========================================================
   // Per-terminal contexts
   // ==========================================================
   // RT1 configuration, descriptor base, self-test words and last command
   smode_rt_ctx #(
      .OFS_CFG  (smode_pkg::OFS_RT1_CFG),
      .OFS_BASE (smode_pkg::OFS_RT1_DESC_BASE),
      .OFS_ST0  (smode_pkg::OFS_RT1_ST_FIRST),
      .OFS_ST1  (smode_pkg::OFS_RT1_ST_SECOND)
   ) u_rt1 (
      .clock         (clock),
      .nrst          (nrst),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .last_we       (last_we1),
      .last_in       (cmd_q),
      .simplified    (simp1),
      .desc_base     (base1),
      .selftest_word (st1),
      .last_cmd      (last1),
      .rd_hit        (hit1),
      .rd_data       (rd1)
   );

   smode_rt_ctx #(
      .OFS_CFG  (smode_pkg::OFS_RT2_CFG),
      .OFS_BASE (smode_pkg::OFS_RT2_DESC_BASE),
      .OFS_ST0  (smode_pkg::OFS_RT2_ST_FIRST),
      .OFS_ST1  (smode_pkg::OFS_RT2_ST_SECOND)
   ) u_rt2 (
      .clock         (clock),
      .nrst          (nrst),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .last_we       (last_we2),
      .last_in       (cmd_q),
      .simplified    (simp2),
      .desc_base     (base2),
      .selftest_word (st2),
      .last_cmd      (last2),
      .rd_hit        (hit2),
      .rd_data       (rd2)
   );

   // ==========================================================
   // Command decode
   // ==========================================================
   assign cmd_tr   = cmd_word[smode_pkg::CMD_TR_BIT];
   assign cmd_code = cmd_word[4:0];
   assign is_mode  = (cmd_word[9:5] == smode_pkg::SA_MODE_A)
                   || (cmd_word[9:5] == smode_pkg::SA_MODE_B);
   assign cmd_simp = cmd_rt ? simp2 : simp1;
   assign has_data = (cmd_code >= smode_pkg::MC_FIRST_DATA);

   // Last command updates only once the message is transacted
   assign last_we1 = (state_q == ST_WAIT_MSG) && msg_done && !rt_q;
   assign last_we2 = (state_q == ST_WAIT_MSG) && msg_done && rt_q;

   // ==========================================================
   // Descriptor addressing
   // ==========================================================
   assign base_sel = rt_q ? base2 : base1;

   always_comb
   begin
      case (state_q)
         ST_TX_RD,
         ST_W4_WR:   word_sel = smode_pkg::DW_MODE_DATA;
         ST_W2_WR:   word_sel = smode_pkg::DW_MSG_INFO;
         ST_W3_WR:   word_sel = smode_pkg::DW_TIME_TAG;
         default:    word_sel = smode_pkg::DW_CONTROL;
      endcase
   end

   // block address is the record itself
   smode_desc_addr u_addr (
      .base (base_sel),
      .tr   (tr_q),
      .code (code_q),
      .word (word_sel),
      .addr (word_addr)
   );

   // ==========================================================
   // Message sequencer
   // ==========================================================
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q     <= ST_IDLE;
         rt_q        <= 1'b0;
         tr_q        <= 1'b0;
         code_q      <= 5'h00;
         own_q       <= 1'b0;
         cmd_q       <= 16'h0000;
         data_wr_q   <= 1'b0;
         ram_addr_q  <= 16'h0000;
         ram_wdata_q <= 16'h0000;
         ram_we_q    <= 1'b0;
         ram_re_q    <= 1'b0;
         tx_valid_q  <= 1'b0;
         tx_data_q   <= 16'h0000;
         commit_q    <= 1'b0;
      end
      else
      begin
         ram_we_q   <= 1'b0;
         ram_re_q   <= 1'b0;
         tx_valid_q <= 1'b0;
         commit_q   <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (cmd_valid)
               begin
                  rt_q      <= cmd_rt;
                  tr_q      <= cmd_tr;
                  code_q    <= cmd_code;
                  cmd_q     <= cmd_word;
                  own_q     <= is_mode && cmd_simp;
                  // no-data codes never touch word 4
                  data_wr_q <= is_mode && cmd_simp && has_data;
                  state_q   <= ST_WAIT_MSG;
                  if (is_mode && cmd_simp && cmd_tr && has_data)
                  begin
                     if (cmd_code == smode_pkg::MC_LAST_COMMAND)
                     begin
                        tx_data_q  <= cmd_rt ? last2 : last1;
                        tx_valid_q <= 1'b1;
                     end
                     else if (cmd_code == smode_pkg::MC_SELFTEST_WORD)
                     begin
                        tx_data_q  <= cmd_rt ? st2 : st1;
                        tx_valid_q <= 1'b1;
                     end
                     else
                        state_q <= ST_TX_RD;
                  end
               end
            ST_TX_RD:
            begin
               // fetch word 4 host preload or zero
               ram_addr_q <= word_addr;
               ram_re_q   <= 1'b1;
               state_q    <= ST_TX_DATA;
            end
            ST_TX_DATA:
               state_q <= ST_W1_RD;
            ST_W1_RD:
            begin
               if (!own_q)
                  state_q <= ST_WAIT_MSG;
               else
               begin
                  tx_data_q  <= ram_rdata;
                  tx_valid_q <= 1'b1;
                  state_q    <= ST_WAIT_MSG;
               end
            end
            ST_WAIT_MSG:
            begin
               // nothing written before the message completes
               if (msg_abort)
                  state_q <= ST_IDLE;
               else if (msg_done && !own_q)
                  state_q <= ST_IDLE;
               else if (msg_done)
               begin
                  ram_addr_q <= word_addr;
                  ram_re_q   <= 1'b1;
                  state_q    <= ST_W1_DATA;
               end
            end
            ST_W1_DATA:
               state_q <= ST_W1_WR;
            ST_W1_WR:
            begin
               // only accessed and broadcast bits change
               ram_addr_q  <= word_addr;
               ram_wdata_q <= ctrl_merge;
               ram_we_q    <= 1'b1;
               state_q     <= ST_W2_WR;
            end
            ST_W2_WR:
            begin
               ram_addr_q  <= word_addr;
               ram_wdata_q <= info_q;
               ram_we_q    <= 1'b1;
               state_q     <= ST_W3_WR;
            end
            ST_W3_WR:
            begin
               ram_addr_q  <= word_addr;
               ram_wdata_q <= time_q;
               ram_we_q    <= 1'b1;
               state_q     <= data_wr_q ? ST_W4_WR : ST_IDLE;
               commit_q    <= !data_wr_q;
            end
            ST_W4_WR:
            begin
               ram_addr_q  <= word_addr;
               ram_wdata_q <= data_q;
               ram_we_q    <= 1'b1;
               commit_q    <= 1'b1;
               state_q     <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Message record capture
   // ==========================================================
   // read data stands only while in ST_W1_WR, so merge there
   always_comb
   begin
      ctrl_merge = ram_rdata;
      ctrl_merge[smode_pkg::CTRL_ACCESSED_BIT] = 1'b1;
      ctrl_merge[smode_pkg::CTRL_BROADCAST_RECEIVED_FLAG_BIT]    = broadcast_received_flag_q;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         info_q  <= 16'h0000;
         time_q  <= 16'h0000;
         data_q  <= 16'h0000;
         broadcast_received_flag_q <= 1'b0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         if ((state_q == ST_WAIT_MSG) && msg_done)
         begin
            info_q  <= msg_info;
            time_q  <= msg_time;
            broadcast_received_flag_q <= msg_broadcast_received_flag;
            data_q  <= tr_q ? tx_data_q : msg_rx_data;
         end
         if (reg_rd)
         begin
            if (reg_addr == smode_pkg::OFS_STATUS)
               rdata_q <= {9'h000, own_q, tr_q, code_q[4:0] & 5'h1F} & 16'h007F
                          | {8'h00, busy, 7'h00};
            else if (hit1)
               rdata_q <= rd1;
            else if (hit2)
               rdata_q <= rd2;
            else
               rdata_q <= 16'h0000;
         end
      end
   end

   // host relies on the device for words 2-3
   assign busy        = (state_q != ST_IDLE);
   assign reg_rdata   = rdata_q;
   assign tx_valid    = tx_valid_q;
   assign tx_data     = tx_data_q;
   assign commit_done = commit_q;
   assign ram_addr    = ram_addr_q;
   assign ram_wdata   = ram_wdata_q;
   assign ram_we      = ram_we_q;
   assign ram_re      = ram_re_q;

endmodule : smode_cmd_store

// file: smode_cmd_store_asserts.sv
// Port checks for the mode-command descriptor store
`timescale 1ns/1ps
module smode_cmd_store_asserts
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_word,
   input  wire logic        msg_done,
   input  wire logic        msg_abort,
   input  wire logic        msg_broadcast_received_flag,
   input  wire logic [15:0] ram_rdata,
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_data,
   input  wire logic        commit_done,
   input  wire logic        busy,
   input  wire logic [15:0] ram_addr,
   input  wire logic [15:0] ram_wdata,
   input  wire logic        ram_we,
   input  wire logic        ram_re
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Helper state
   // ==========================================================
   logic       done_q;
   logic       broadcast_received_flag_q;
   logic       data_q;
   logic [2:0] wrun_q;
   wire        take = cmd_valid && !busy;

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         done_q <= 1'b0;
      else if (commit_done || msg_abort || take)
         done_q <= 1'b0;
      else if (msg_done)
         done_q <= 1'b1;

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         broadcast_received_flag_q <= 1'b0;
         data_q  <= 1'b0;
      end
      else
      begin
         if (msg_done)
            broadcast_received_flag_q <= msg_broadcast_received_flag;
         if (take)
            data_q <= cmd_word[4];
      end

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         wrun_q <= 3'h0;
      else
         wrun_q <= ram_we ? wrun_q + 3'h1 : 3'h0;

   // ==========================================================
   // Assertions
   // ==========================================================
   commit_after_done_a: assert property (
      ram_we |-> done_q) else $error("RAM written before message done");
   abort_no_write_a: assert property (
      msg_abort |-> ##1 (!ram_we && !commit_done) [*6]) else $error("Write after abort");
   word_order_a: assert property (
      ram_we && $past(ram_we) |-> ram_addr == $past(ram_addr) + 16'h0001)
      else $error("Descriptor words out of order");
   control_bits_a: assert property (
      ram_we && !$past(ram_we) |-> ram_wdata[smode_pkg::CTRL_ACCESSED_BIT]
         && ram_wdata[smode_pkg::CTRL_BROADCAST_RECEIVED_FLAG_BIT] == broadcast_received_flag_q) else $error("Control bits wrong");
   tx_pulse_a: assert property (
      tx_valid |=> !tx_valid) else $error("tx_valid longer than one cycle");
   tx_from_ram_a: assert property (
      tx_valid && $past(ram_re, 2) |-> tx_data == $past(ram_rdata))
      else $error("Transmit word not from descriptor");
   record_length_a: assert property (
      commit_done |-> ram_we && wrun_q == (data_q ? 3'h3 : 3'h2))
      else $error("Wrong number of descriptor writes");
   subaddr_quiet_a: assert property (
      take && cmd_word[9:5] != smode_pkg::SA_MODE_A && cmd_word[9:5] != smode_pkg::SA_MODE_B
         |-> ##1 (!ram_re && !ram_we) [*4]) else $error("RAM access for subaddress command");

   commit_c: cover property (commit_done && data_q);
   tx_c: cover property (tx_valid);
   abort_c: cover property (msg_abort && busy);
endmodule : smode_cmd_store_asserts

// file: smode_ram_model.sv
// Shared RAM model on the descriptor port
`timescale 1ns/1ps
module smode_ram_model
(
   input  wire logic        clock,
   input  wire logic [15:0] ram_addr,
   input  wire logic [15:0] ram_wdata,
   input  wire logic        ram_we,
   input  wire logic        ram_re,
   output logic      [15:0] ram_rdata
);
   logic [15:0] mem [0:1023];
   int          wr_count;

   initial
   begin
      foreach (mem[i])
         mem[i] = 16'h0000;
      wr_count  = 0;
      ram_rdata = 16'h0000;
   end

   always @(posedge clock)
   begin
      if (ram_we)
      begin
         mem[ram_addr[9:0]] <= ram_wdata;
         wr_count           <= wr_count + 1;
      end
      // Read data lasts one cycle, then turns to noise
      ram_rdata <= ram_re ? mem[ram_addr[9:0]] : ~ram_rdata;
   end
endmodule : smode_ram_model

// file: rt_simplified_mode_cmd_store_tb_top.sv
// Testbench for the mode-command descriptor store
`timescale 1ns/1ps
module rt_simplified_mode_cmd_store_tb_top;
   localparam logic [15:0] B1 = 16'h0100;
   localparam logic [15:0] B2 = 16'h0200;
   localparam logic [7:0]  RA [7] = '{8'h1E, 8'h1F, 8'h27, 8'h28, 8'h40, 8'h42, 8'h10};
   logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic cmd_valid = 1'b0, cmd_rt = 1'b0, msg_done = 1'b0, msg_abort = 1'b0, msg_broadcast_received_flag = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, cmd_word = 16'h0000, msg_info = 16'h0000;
   logic [15:0] msg_time = 16'h0000, msg_rx_data = 16'h0000;
   logic [15:0] reg_rdata, tx_data, ram_addr, ram_wdata, ram_rdata;
   logic        tx_valid, commit_done, busy, ram_we, ram_re;
   int          err_count = 0;
   int          total_checks = 0;

   always #50 clock = ~clock;

   smode_cmd_store dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
      .cmd_rt(cmd_rt), .cmd_word(cmd_word), .msg_done(msg_done), .msg_abort(msg_abort),
      .msg_broadcast_received_flag(msg_broadcast_received_flag), .msg_info(msg_info), .msg_time(msg_time),
      .msg_rx_data(msg_rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .commit_done(commit_done), .busy(busy), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
   smode_ram_model ram (.clock(clock), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   function automatic logic [9:0] da(input logic [15:0] b, input logic [15:0] w,
                                     input logic [1:0] k);
      logic [15:0] a;
      a = b + {8'h00, w[10], w[4:0], k};
      return a[9:0];
   endfunction : da

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      check(reg_rdata, e, "register read");
   endtask : reg_read

   // One message: command, optional transmit word, then done or abort
   task automatic send(input logic rt, input logic [15:0] w, input logic ab, input logic bc,
                       input logic [15:0] rx, input logic wt, output logic [15:0] tx);
      int n;
      tx = 16'h0000;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_rt    <= rt;
      cmd_word  <= w;
      @(posedge clock);
      cmd_valid <= 1'b0;
      n = 0;
      while (wt && n < 10)
      begin
         @(negedge clock);
         n++;
         if (tx_valid === 1'b1)
         begin
            tx = tx_data;
            n  = 99;
         end
      end
      check({15'h0000, !wt || n == 99}, 16'h0001, "tx_valid seen");
      @(posedge clock);
      msg_done    <= !ab;
      msg_abort   <= ab;
      msg_broadcast_received_flag   <= bc;
      msg_info    <= ~w;
      msg_time    <= w + 16'h1000;
      msg_rx_data <= rx;
      @(posedge clock);
      msg_done  <= 1'b0;
      msg_abort <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (busy !== 1'b0 && n < 20);
      // Last descriptor write lands one edge after busy falls
      @(negedge clock);
   endtask : send

   task automatic chk_rec(input logic [15:0] b, input logic [15:0] w, input logic [15:0] c,
                          input logic [15:0] d);
      check(ram.mem[da(b, w, 2'h0)], c, "control word");
      check(ram.mem[da(b, w, 2'h1)], ~w, "info word");
      check(ram.mem[da(b, w, 2'h2)], w + 16'h1000, "time tag");
      check(ram.mem[da(b, w, 2'h3)], d, "mode data");
   endtask : chk_rec

   initial
   begin
      repeat (3000) @(posedge clock);
      err_count++;
      print_verdict();
   end

   initial
   begin
      logic [15:0] tx;
      int          n0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      foreach (RA[i])
         reg_read(RA[i], 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         reg_write(RA[i], {RA[i], RA[i]});
         reg_read(RA[i], {RA[i], RA[i]});
      end
      reg_write(smode_pkg::OFS_RT1_DESC_BASE, B1);
      reg_write(smode_pkg::OFS_RT2_DESC_BASE, B2);
      reg_write(smode_pkg::OFS_RT1_CFG, 16'h0001);
      $display("Test registers done");
      send(1'b0, 16'h0011, 1'b0, 1'b1, 16'hBEEF, 1'b0, tx);
      chk_rec(B1, 16'h0011, 16'h0A00, 16'hBEEF);
      // Host touches only word 4
      ram.mem[da(B1, 16'h0403, 2'h3)] = 16'hA5A5;
      send(1'b0, 16'h0403, 1'b0, 1'b0, 16'h0000, 1'b0, tx);
      chk_rec(B1, 16'h0403, 16'h0800, 16'hA5A5);
      $display("Test receive done");
      ram.mem[da(B1, 16'h0410, 2'h3)] = 16'h1357;
      send(1'b0, 16'h0410, 1'b0, 1'b0, 16'h0000, 1'b1, tx);
      check(tx, 16'h1357, "vector word");
      send(1'b0, 16'h0414, 1'b0, 1'b0, 16'h0000, 1'b1, tx);
      check(tx, 16'h0000, "default word");
      send(1'b0, 16'h0412, 1'b0, 1'b0, 16'h0000, 1'b1, tx);
      check(tx, 16'h0414, "last command");
      chk_rec(B1, 16'h0412, 16'h0800, 16'h0414);
      $display("Test transmit done");
      n0 = ram.wr_count;
      send(1'b1, 16'h0011, 1'b0, 1'b0, 16'h3333, 1'b0, tx);
      send(1'b0, 16'h0051, 1'b0, 1'b0, 16'h2222, 1'b0, tx);
      check(16'(ram.wr_count), 16'(n0), "writes while not selected");
      send(1'b0, 16'h0011, 1'b1, 1'b0, 16'h1111, 1'b0, tx);
      check(16'(ram.wr_count), 16'(n0), "writes after abort");
      check(ram.mem[da(B1, 16'h0011, 2'h3)], 16'hBEEF, "record after abort");
      for (int i = 0; i < 4; i++)
      begin
         reg_write(i < 2 ? smode_pkg::OFS_RT1_CFG : smode_pkg::OFS_RT2_CFG,
                   i[0] ? 16'h0003 : 16'h0001);
         send(i[1], 16'h0413, 1'b0, 1'b0, 16'h0000, 1'b1, tx);
         check(tx, {RA[i], RA[i]}, "self-test word");
         check(ram.mem[da(i[1] ? B2 : B1, 16'h0413, 2'h3)], tx, "self-test stored");
      end
      reg_read(smode_pkg::OFS_STATUS, 16'h0073);
      $display("Test reports done");
      print_verdict();
   end
endmodule : rt_simplified_mode_cmd_store_tb_top

bind smode_cmd_store smode_cmd_store_asserts chk (.clock(clock), .nrst(nrst),
   .cmd_valid(cmd_valid), .cmd_word(cmd_word), .msg_done(msg_done), .msg_abort(msg_abort),
   .msg_broadcast_received_flag(msg_broadcast_received_flag), .ram_rdata(ram_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
   .commit_done(commit_done), .busy(busy), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
   .ram_we(ram_we), .ram_re(ram_re));
